// >>> src/ntb_pkg.sv
// shared constants and carriers for the bridge memory window setup registers
package ntb_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [11:0] NTB_OFF_DOWN2_SETUP = 12'h00C;
    localparam logic [11:0] NTB_OFF_DOWN3_TBASE = 12'h010;
    localparam logic [11:0] NTB_OFF_DOWN3_SETUP = 12'h014;
    localparam logic [11:0] NTB_OFF_DOWN3_UPPER = 12'h018;
    localparam logic [11:0] NTB_OFF_UP3_SETUP = 12'h034;

    // ****************************************
    // field positions
    // ****************************************
    localparam int NTB_TYPE_BIT = 0;
    localparam int NTB_ATYPE_LSB = 1;
    localparam int NTB_PF_BIT = 3;
    localparam int NTB_SIZE_LSB = 12;
    localparam int NTB_DOWN_SIZE_MSB = 30;
    localparam int NTB_EN_BIT = 31;
    localparam logic [1:0] NTB_ATYPE_32 = 2'h0;
    localparam logic [1:0] NTB_ATYPE_64 = 2'h1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] NTB_RST_DOWN_SETUP = 32'h0000_0000;
    localparam logic [31:0] NTB_RST_DOWN3_TBASE = 32'h0000_0000;
    localparam logic [31:0] NTB_RST_DOWN3_UPPER = 32'h0000_0000;
    localparam logic [31:0] NTB_RST_UP3_SETUP = 32'h0000_0002;

    // ****************************************
    // write masks: ordinary bus path and init path
    // ****************************************
    localparam logic [31:0] NTB_BUS_DOWN_SETUP = 32'h0000_0000;
    localparam logic [31:0] NTB_INIT_DOWN_SETUP = 32'hFFFF_F00E;
    localparam logic [31:0] NTB_RW_TBASE = 32'hFFFF_F000;
    localparam logic [31:0] NTB_RW_UPPER = 32'hFFFF_FFFF;
    localparam logic [31:0] NTB_RW_UP3_SETUP = 32'hFFFF_F008;

    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] be;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ntb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } ntb_rsp_s;

    typedef struct packed {
        logic [31:0] down2_setup;
        logic [31:0] down3_tbase;
        logic [31:0] down3_setup;
        logic [31:0] down3_upper;
        logic [31:0] up3_setup;
    } ntb_regs_s;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [31:0] addr;
    } ntb_xlat_s;

endpackage : ntb_pkg

// >>> src/ntb_window_regs.sv
// memory window setup registers with two bus ports, init load path and window 3 translation
// Contract
// - type bit reads zero: memory space
// - address type 00 is 32-bit, down reset
// - upstream window 3 address type fixed 01
// - size bit one makes base bit writable; here translated base bits 31:12 are writable whatever the size
// - size bit zero read-only; sizes reset zero
// - upper setup mask bits 30:0 writable
// - setup bit 31 enables window, resets zero
// - upper setup bit 31 writable enable
// - translated base bits 31:12 writable, reset zero
// - registers reachable from primary and secondary port
`timescale 1ns/10ps
module ntb_window_regs
    import ntb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire ntb_req_s req_p,
    input wire ntb_req_s req_s,
    input wire logic init_write_path,
    input wire logic [11:0] init_addr,
    input wire logic [31:0] init_wdata,
    input wire logic xlat_valid,
    input wire logic [31:0] xlat_addr,
    output ntb_rsp_s rsp_p,
    output ntb_rsp_s rsp_s,
    output ntb_regs_s cfg,
    output ntb_xlat_s fwd
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        ntb_regs_s regs;
        ntb_rsp_s rsp_p;
        ntb_rsp_s rsp_s;
        ntb_xlat_s fwd;
    } ntb_state_s;

    ntb_state_s st_q;
    ntb_state_s st_d;
    logic [31:0] xmask;

    function automatic logic [31:0] ntb_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [31:0] m);
        logic [31:0] lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~(m & lanes)) | (wd & m & lanes);
    endfunction : ntb_merge

    function automatic logic [31:0] ntb_read(input ntb_regs_s r, input logic [11:0] a);
        case (a)
            NTB_OFF_DOWN2_SETUP: return r.down2_setup;
            NTB_OFF_DOWN3_TBASE: return r.down3_tbase;
            NTB_OFF_DOWN3_SETUP: return r.down3_setup;
            NTB_OFF_DOWN3_UPPER: return r.down3_upper;
            NTB_OFF_UP3_SETUP: return r.up3_setup;
            default: return 32'h0000_0000;
        endcase
    endfunction : ntb_read

    // bus writes and init writes differ only in the mask of the downstream setups
    function automatic ntb_regs_s ntb_write(input ntb_regs_s r, input logic [11:0] a,
                                            input logic [31:0] d, input logic [3:0] be,
                                            input logic init);
        ntb_regs_s n;
        logic [31:0] dm;
        n = r;
        // bit 0 sits outside every setup mask, so the type always reads memory space
        dm = init ? NTB_INIT_DOWN_SETUP : NTB_BUS_DOWN_SETUP;
        case (a)
            NTB_OFF_DOWN2_SETUP: n.down2_setup = ntb_merge(r.down2_setup, d, be, dm);
            NTB_OFF_DOWN3_TBASE: n.down3_tbase = ntb_merge(r.down3_tbase, d, be, NTB_RW_TBASE);
            NTB_OFF_DOWN3_SETUP: n.down3_setup = ntb_merge(r.down3_setup, d, be, dm);
            NTB_OFF_DOWN3_UPPER: n.down3_upper = ntb_merge(r.down3_upper, d, be, NTB_RW_UPPER);
            // type and address type stay outside the mask, so they never move
            NTB_OFF_UP3_SETUP: n.up3_setup = ntb_merge(r.up3_setup, d, be, NTB_RW_UP3_SETUP);
            default: n = r;
        endcase
        return n;
    endfunction : ntb_write

    // ****************************************
    // next state
    // ****************************************
    // size field of the downstream window selects translated bits; bit 31 keeps the original
    assign xmask = {1'b0, st_q.regs.down3_setup[NTB_DOWN_SIZE_MSB:NTB_SIZE_LSB], 12'h000};

    always_comb begin
        st_d = st_q;
        st_d.rsp_p = '0;
        st_d.rsp_s = '0;
        // primary has priority; secondary holds its request until acknowledged
        if (req_p.valid) begin
            st_d.rsp_p.ack = 1'b1;
            if (req_p.write) begin
                st_d.regs = ntb_write(st_q.regs, req_p.addr, req_p.wdata, req_p.be, 1'b0);
            end else begin
                st_d.rsp_p.rdata = ntb_read(st_q.regs, req_p.addr);
            end
        end else if (req_s.valid) begin
            st_d.rsp_s.ack = 1'b1;
            if (req_s.write) begin
                st_d.regs = ntb_write(st_q.regs, req_s.addr, req_s.wdata, req_s.be, 1'b0);
            end else begin
                st_d.rsp_s.rdata = ntb_read(st_q.regs, req_s.addr);
            end
        end
        // the load path lands after the bus write, so it wins a same-cycle clash
        if (init_write_path) begin
            st_d.regs = ntb_write(st_d.regs, init_addr, init_wdata, 4'hF, 1'b1);
        end
        st_d.fwd.valid = xlat_valid;
        st_d.fwd.hit = xlat_valid && st_q.regs.down3_setup[NTB_EN_BIT];
        if (st_d.fwd.hit) begin
            st_d.fwd.addr = (st_q.regs.down3_tbase & xmask) | (xlat_addr & ~xmask);
        end else begin
            st_d.fwd.addr = xlat_addr;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
            st_q.regs.down2_setup <= NTB_RST_DOWN_SETUP;
            st_q.regs.down3_setup <= NTB_RST_DOWN_SETUP;
            st_q.regs.down3_tbase <= NTB_RST_DOWN3_TBASE;
            st_q.regs.down3_upper <= NTB_RST_DOWN3_UPPER;
            st_q.regs.up3_setup <= NTB_RST_UP3_SETUP;
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp_p = st_q.rsp_p;
    assign rsp_s = st_q.rsp_s;
    assign cfg = st_q.regs;
    assign fwd = st_q.fwd;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_sec_alone;
        req_s.valid && !req_p.valid;
    endsequence

    sequence s_sec_ack;
        rsp_s.ack && !rsp_p.ack;
    endsequence

    sequence s_bus_down2_write;
        req_p.valid && req_p.write && req_p.addr == NTB_OFF_DOWN2_SETUP && !init_write_path;
    endsequence

    AST_TYPE_MEMORY: assert property (cfg.down2_setup[NTB_TYPE_BIT] == 1'b0 &&
            cfg.down3_setup[NTB_TYPE_BIT] == 1'b0 && cfg.up3_setup[NTB_TYPE_BIT] == 1'b0)
        else $error("window type bit not zero");
    AST_DOWN_ATYPE_HOLD: assert property ($changed(cfg.down3_setup[2:1]) |->
            $past(init_write_path))
        else $error("downstream address type moved without init write");
    AST_UP_ATYPE_64: assert property (cfg.up3_setup[2:1] == NTB_ATYPE_64)
        else $error("upstream window 3 not 64-bit");
    AST_BUS_REFUSED: assert property (s_bus_down2_write |=> $stable(cfg.down2_setup))
        else $error("bus write changed init-only setup");
    AST_TBASE_LOW: assert property (cfg.down3_tbase[11:0] == 12'h000)
        else $error("translated base low bits not zero");
    AST_UPPER_WRITE: assert property (req_p.valid && req_p.write &&
            req_p.be == 4'hF && req_p.addr == NTB_OFF_DOWN3_UPPER && !init_write_path
            |=> cfg.down3_upper == $past(req_p.wdata))
        else $error("upper setup write lost");
    // back to back requests keep ack high, so the drop is owed only after a lone request
    AST_PRI_ACK: assert property (req_p.valid |=> rsp_p.ack ##1
            (!rsp_p.ack || $past(req_p.valid)))
        else $error("primary request not acknowledged");
    AST_SEC_ACK: assert property (s_sec_alone |=> s_sec_ack)
        else $error("secondary request not acknowledged");
    AST_XLAT_HIT: assert property (xlat_valid && cfg.down3_setup[NTB_EN_BIT] |=>
            fwd.hit && fwd.addr == (($past(cfg.down3_tbase) & $past(xmask)) |
            ($past(xlat_addr) & ~$past(xmask))))
        else $error("translated address wrong");
    AST_XLAT_OFF: assert property (xlat_valid && !cfg.down3_setup[NTB_EN_BIT] |=>
            !fwd.hit && fwd.addr == $past(xlat_addr))
        else $error("disabled window translated");

    // ****************************************
    // checks on the write paths and port arbitration
    // ****************************************
    sequence s_both_req;
        req_s.valid && req_p.valid;
    endsequence

    sequence s_bus_tbase_write;
        req_p.valid && req_p.write && req_p.be == 4'hF && req_p.addr == NTB_OFF_DOWN3_TBASE &&
            !init_write_path;
    endsequence

    sequence s_bus_up3_write;
        req_p.valid && req_p.write && req_p.be == 4'hF && req_p.addr == NTB_OFF_UP3_SETUP &&
            !init_write_path;
    endsequence

    sequence s_bus_down3_write;
        req_p.valid && req_p.write && req_p.addr == NTB_OFF_DOWN3_SETUP && !init_write_path;
    endsequence

    sequence s_init_down3;
        init_write_path && init_addr == NTB_OFF_DOWN3_SETUP;
    endsequence

    // secondary must wait its turn while primary holds the port
    AST_SEC_STALL: assert property (s_both_req |=> !rsp_s.ack)
        else $error("secondary taken while primary requests");
    AST_TBASE_WRITE: assert property (s_bus_tbase_write |=>
            cfg.down3_tbase == ($past(req_p.wdata) & NTB_RW_TBASE))
        else $error("translated base write wrong");
    // fixed fields keep their reset value, so mask and reset value give the result
    AST_UP3_WRITE: assert property (s_bus_up3_write |=>
            cfg.up3_setup == (($past(req_p.wdata) & NTB_RW_UP3_SETUP) | NTB_RST_UP3_SETUP))
        else $error("upstream window 3 setup write wrong");
    AST_BUS_REFUSED_D3: assert property (s_bus_down3_write |=> $stable(cfg.down3_setup))
        else $error("bus write changed downstream window 3 setup");
    AST_INIT_DOWN3: assert property (s_init_down3 |=>
            cfg.down3_setup == ($past(init_wdata) & NTB_INIT_DOWN_SETUP))
        else $error("init write to downstream window 3 setup lost");

endmodule : ntb_window_regs

// >>> verification/ntb_host_model.sv
// host model driving the primary and secondary register ports
`timescale 1ns/10ps
module ntb_host_model
    import ntb_pkg::*;
(
    input wire logic clk,
    input wire ntb_rsp_s rsp_p,
    input wire ntb_rsp_s rsp_s,
    output ntb_req_s req_p,
    output ntb_req_s req_s
);
    initial begin
        req_p = '0;
        req_s = '0;
    end
    // ****************************************
    // one access; a nonzero be makes it a write
    // ****************************************
    task automatic access(input logic sec, input logic [3:0] be, input logic [11:0] a,
                          input logic [31:0] d, output logic [31:0] rd);
        ntb_req_s r;
        r = '{valid: 1'b1, write: |be, be: be, addr: a, wdata: d};
        @(negedge clk);
        if (sec) req_s = r;
        else req_p = r;
        // dropped once ack shows, else a held request is taken again
        do @(negedge clk); while (!(sec ? rsp_s.ack : rsp_p.ack));
        rd = sec ? rsp_s.rdata : rsp_p.rdata;
        if (sec) req_s = '0;
        else req_p = '0;
    endtask : access
endmodule : ntb_host_model

// >>> verification/ntb_memory_window_setup_regs_test.sv
// self-checking bench for the window setup registers
`timescale 1ns/10ps
module ntb_memory_window_setup_regs_test;
    import ntb_pkg::*;
    typedef struct packed {
        logic init;
        logic sec;
        logic [3:0] be;
        logic [11:0] addr;
        logic [31:0] wd;
        logic [31:0] ex;
    } ntb_row_s;
    logic clk, reset, init_write_path, xlat_valid;
    logic [11:0] init_addr;
    logic [31:0] init_wdata, xlat_addr, rd, rd2;
    ntb_req_s req_p, req_s;
    ntb_rsp_s rsp_p, rsp_s;
    ntb_regs_s cfg;
    ntb_xlat_s fwd;
    int fail_count = 0;
    int compares = 0;
    ntb_row_s rows [13] = '{
        {1'b0, 1'b0, 4'h0, 12'h00C, 32'h0, 32'h0},
        {1'b0, 1'b0, 4'h0, 12'h010, 32'h0, 32'h0},
        {1'b0, 1'b0, 4'h0, 12'h014, 32'h0, 32'h0},
        {1'b0, 1'b0, 4'h0, 12'h018, 32'h0, 32'h0},
        {1'b0, 1'b0, 4'h0, 12'h034, 32'h0, 32'h2},
        {1'b0, 1'b0, 4'hF, 12'h010, 32'hFFFFFFFF, 32'hFFFFF000},
        {1'b0, 1'b0, 4'hF, 12'h018, 32'hFFFFFFFF, 32'hFFFFFFFF},
        {1'b0, 1'b1, 4'h1, 12'h018, 32'h0, 32'hFFFFFF00},
        {1'b0, 1'b0, 4'hF, 12'h034, 32'hFFFFFFFF, 32'hFFFFF00A},
        {1'b0, 1'b0, 4'hF, 12'h014, 32'hFFFFFFFF, 32'h0},
        {1'b1, 1'b0, 4'h0, 12'h014, 32'hFFFFFFFF, 32'hFFFFF00E},
        {1'b1, 1'b0, 4'h0, 12'h00C, 32'h8000F002, 32'h8000F002},
        {1'b0, 1'b1, 4'hF, 12'h020, 32'hFFFFFFFF, 32'h0}
    };
    ntb_window_regs ntb_window_regs_inst (.clk(clk), .reset(reset), .req_p(req_p),
        .req_s(req_s), .init_write_path(init_write_path), .init_addr(init_addr),
        .init_wdata(init_wdata), .xlat_valid(xlat_valid), .xlat_addr(xlat_addr),
        .rsp_p(rsp_p), .rsp_s(rsp_s), .cfg(cfg), .fwd(fwd));
    ntb_host_model ntb_host_model_inst (.clk(clk), .rsp_p(rsp_p), .rsp_s(rsp_s),
        .req_p(req_p), .req_s(req_s));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic init_wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        init_write_path = 1'b1;
        init_addr = a;
        init_wdata = d;
        @(negedge clk);
        init_write_path = 1'b0;
    endtask : init_wr
    task automatic xlat(input logic [31:0] a, input logic [33:0] exp);
        @(negedge clk);
        xlat_valid = 1'b1;
        xlat_addr = a;
        @(negedge clk);
        xlat_valid = 1'b0;
        chk(fwd, exp);
    endtask : xlat
    task automatic end_sim;
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // run is under a hundred cycles; watchdog allows ten thousand
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end
    initial begin
        reset = 1'b1;
        init_write_path = 1'b0;
        init_addr = 12'h000;
        init_wdata = 32'h0;
        xlat_valid = 1'b0;
        xlat_addr = 32'h0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].init) init_wr(rows[i].addr, rows[i].wd);
            else if (|rows[i].be)
                ntb_host_model_inst.access(rows[i].sec, rows[i].be, rows[i].addr,
                    rows[i].wd, rd);
            ntb_host_model_inst.access(!rows[i].sec, 4'h0, rows[i].addr, 32'h0, rd);
            chk(rd, rows[i].ex);
        end
        // both ports at once: secondary waits behind primary
        fork
            ntb_host_model_inst.access(1'b0, 4'h0, 12'h010, 32'h0, rd);
            ntb_host_model_inst.access(1'b1, 4'h0, 12'h034, 32'h0, rd2);
        join
        chk(rd, 32'hFFFFF000);
        chk(rd2, 32'hFFFFF00A);
        init_wr(12'h014, 32'h8000F000);
        xlat(32'h12345678, {2'b11, 32'h1234F678});
        init_wr(12'h014, 32'h0000F000);
        xlat(32'h12345678, {2'b10, 32'h12345678});
        // second reset in mid-run restores every field
        @(negedge clk);
        reset = 1'b1;
        #1;
        chk(cfg, {128'h0, 32'h2});
        chk({rsp_p, rsp_s, fwd}, '0);
        @(negedge clk);
        reset = 1'b0;
        // first requests right after release must see the reset values
        ntb_host_model_inst.access(1'b0, 4'h0, 12'h034, 32'h0, rd);
        chk(rd, 32'h2);
        ntb_host_model_inst.access(1'b1, 4'h0, 12'h014, 32'h0, rd);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule : ntb_memory_window_setup_regs_test
